// File: logic/rucl_defines.svh
// Constants for the remote update configuration loader.
// Assumes inclusion by the package and the design files by bare name.
`ifndef RUCL_DEFINES_SVH
`define RUCL_DEFINES_SVH

// ----------------------------------------------------------------------
// Page addresses and widths
// ----------------------------------------------------------------------
`define RUCL_PAGE_W          3
`define RUCL_FACTORY_PAGE    3'h0
`define RUCL_MAX_APP_PAGES   7
`define RUCL_WD_W            12

// ----------------------------------------------------------------------
// Cause codes held in the status word
// ----------------------------------------------------------------------
`define RUCL_CAUSE_W         2
`define RUCL_CAUSE_POWERUP   2'h0
`define RUCL_CAUSE_LOAD_ERR  2'h1
`define RUCL_CAUSE_WATCHDOG  2'h2
`define RUCL_CAUSE_PIN       2'h3

// ----------------------------------------------------------------------
// Timing: initialization length and watchdog tick divider
// ----------------------------------------------------------------------
`define RUCL_INIT_NS         80
`define RUCL_CLK_NS          10
`define RUCL_INIT_CYC        ((`RUCL_INIT_NS + `RUCL_CLK_NS - 1) / `RUCL_CLK_NS)
`define RUCL_TICK_DIV        16

`endif

// File: logic/rucl_pkg.sv
// Types shared by the configuration loader files.
// Assumes rucl_defines.svh is on the include path.
`include "rucl_defines.svh"

package rucl_pkg;

  // ----------------------------------------------------------------------
  // Loader phases
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RUCL_ST_RESET,
    RUCL_ST_LOAD,
    RUCL_ST_INIT,
    RUCL_ST_USER
  } rucl_state_t;

  // Status word readable by factory logic
  typedef struct packed {
    logic [`RUCL_CAUSE_W-1:0] cause;
    logic [`RUCL_PAGE_W-1:0]  failed_page;
    logic                     factory_active;
  } rucl_status_t;

  // Control word written by factory logic
  typedef struct packed {
    logic [`RUCL_PAGE_W-1:0]  next_page;
    logic                     wd_enable;
    logic [`RUCL_WD_W-1:0]    wd_timeout;
  } rucl_ctrl_t;

endpackage : rucl_pkg

// File: logic/rucl_watchdog.sv
// User watchdog counter for application images.
// Assumes a tick enable from the parent and a synchronous clear.
`timescale 1ns/1ps
`include "rucl_defines.svh"

module rucl_watchdog
  import rucl_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  run,
  input  wire logic                  tick,
  input  wire logic                  restart,
  input  wire logic [`RUCL_WD_W-1:0] timeout,
  output logic                       expired
);

  logic [`RUCL_WD_W-1:0] count_reg;
  logic [`RUCL_WD_W-1:0] count_next;
  logic                  hit;

  // Terminal count compare
  assign hit = run && (count_reg >= timeout);

  // Count while running, clear on restart or when stopped
  assign count_next = (!run || restart) ? '0
                    : tick ? count_reg + {{(`RUCL_WD_W-1){1'b0}}, 1'b1}
                    : count_reg;

  // ----------------------------------------------------------------------
  // Counter register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign expired = hit && !restart;

endmodule : rucl_watchdog

// File: logic/rucl_loader.sv
// Remote update configuration loader: page selection, fallback, I/O gate.
// Assumes a paged memory that reports load done/error on the same clock;
// pins from outside pass a three-stage synchroniser here.
`timescale 1ns/1ps
`include "rucl_defines.svh"

module rucl_loader
  import rucl_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic                    reconfig_pin_n,
  input  wire logic                    chain_cfg_enable_in,
  output logic                         chain_cfg_enable_out,
  output logic [`RUCL_PAGE_W-1:0]      load_page,
  output logic                         load_start,
  input  wire logic                    load_done,
  input  wire logic                    load_error,
  input  wire logic                    image_remote_capable,
  input  wire logic                    ctrl_write,
  input  wire rucl_ctrl_t              ctrl_in,
  input  wire logic                    wd_restart,
  input  wire logic                    reconfig_req,
  output rucl_status_t                 status,
  output logic                         user_mode,
  output logic                         io_oe_n,
  output logic                         io_pullup,
  output logic                         user_reset_n
);

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [2:0] pin_sync_reg;
  logic [2:0] ce_sync_reg;
  logic       pin_level_reg;
  logic       ce_level_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Three stages; level changes when stage two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_reg  <= 3'h7;
      ce_sync_reg   <= 3'h7;
      pin_level_reg <= 1'b1;
      ce_level_reg  <= 1'b1;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], reconfig_pin_n};
      ce_sync_reg  <= {ce_sync_reg[1:0], chain_cfg_enable_in};
      if (pin_sync_reg[2] == pin_sync_reg[1]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
      if (ce_sync_reg[2] == ce_sync_reg[1]) begin
        ce_level_reg <= ce_sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  rucl_state_t                state_reg, state_next;
  logic [`RUCL_PAGE_W-1:0]    page_reg, page_next;
  rucl_ctrl_t                 ctrl_reg, ctrl_next;
  rucl_status_t               status_reg, status_next;
  logic                       capable_reg, capable_next;
  logic [7:0]                 init_cnt_reg, init_cnt_next;
  logic [4:0]                 tick_cnt_reg;
  logic                       tick;
  logic                       wd_expired;
  logic                       pin_fall;
  logic                       pin_prev_reg;
  logic                       chain_on;
  logic                       is_factory;
  logic                       wd_run;
  logic                       wd_ok_restart;

  // Legal application page: 1 to 7, factory page is never a target
  function automatic logic page_is_app(input logic [`RUCL_PAGE_W-1:0] p);
    page_is_app = (p != `RUCL_FACTORY_PAGE);
  endfunction : page_is_app

  assign chain_on   = !ce_level_reg;
  assign pin_fall   = pin_prev_reg && !pin_level_reg;
  assign is_factory = (page_reg == `RUCL_FACTORY_PAGE);
  // Watchdog only runs for application images in user mode
  assign wd_run = (state_reg == RUCL_ST_USER) && !is_factory
                  && ctrl_reg.wd_enable;
  // Restart honoured only from a remote-update capable image
  assign wd_ok_restart = wd_restart && capable_reg;

  // Watchdog tick divider
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 5'h00;
      pin_prev_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick ? 5'h00 : tick_cnt_reg + 5'h01;
      pin_prev_reg <= pin_level_reg;
    end
  end
  assign tick = (tick_cnt_reg == 5'(`RUCL_TICK_DIV - 1));

  rucl_watchdog u_wd (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (wd_run),
    .tick    (tick),
    .restart (wd_ok_restart),
    .timeout (ctrl_reg.wd_timeout),
    .expired (wd_expired)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    page_next     = page_reg;
    ctrl_next     = ctrl_reg;
    status_next   = status_reg;
    capable_next  = capable_reg;
    init_cnt_next = init_cnt_reg;
    case (state_reg)
      RUCL_ST_RESET: begin
        // Power-up always starts from the factory page
        page_next = `RUCL_FACTORY_PAGE;
        if (chain_on) begin
          state_next = RUCL_ST_LOAD;
        end
      end
      RUCL_ST_LOAD: begin
        if (load_error) begin
          // Record cause, fall back to factory
          status_next.cause       = `RUCL_CAUSE_LOAD_ERR;
          status_next.failed_page = page_reg;
          page_next               = `RUCL_FACTORY_PAGE;
          if (is_factory) begin
            state_next = RUCL_ST_RESET;
          end
        end else if (load_done) begin
          capable_next  = image_remote_capable;
          init_cnt_next = 8'h00;
          state_next    = RUCL_ST_INIT;
        end
      end
      RUCL_ST_INIT: begin
        init_cnt_next = init_cnt_reg + 8'h01;
        if (init_cnt_reg == 8'(`RUCL_INIT_CYC - 1)) begin
          state_next = RUCL_ST_USER;
        end
      end
      RUCL_ST_USER: begin
        if (is_factory && ctrl_write && page_is_app(ctrl_in.next_page)) begin
          ctrl_next = ctrl_in;
        end
        if (wd_expired) begin
          status_next.cause       = `RUCL_CAUSE_WATCHDOG;
          status_next.failed_page = page_reg;
          page_next  = `RUCL_FACTORY_PAGE;
          state_next = RUCL_ST_LOAD;
        end else if (reconfig_req) begin
          // Factory jumps to the chosen page; applications go back home
          page_next  = is_factory ? ctrl_reg.next_page
                                  : `RUCL_FACTORY_PAGE;
          state_next = RUCL_ST_LOAD;
        end
      end
      default: begin
        state_next = RUCL_ST_RESET;
      end
    endcase
    // Reconfig pin overrides the next state, page and cause outside the reset state and reloads the factory page
    if (pin_fall && state_reg != RUCL_ST_RESET) begin
      status_next.cause = `RUCL_CAUSE_PIN;
      page_next  = `RUCL_FACTORY_PAGE;
      state_next = RUCL_ST_LOAD;
    end
    status_next.factory_active = (page_next == `RUCL_FACTORY_PAGE);
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= RUCL_ST_RESET;
      page_reg     <= `RUCL_FACTORY_PAGE;
      ctrl_reg     <= '0;
      status_reg   <= '{cause: `RUCL_CAUSE_POWERUP, failed_page: 3'h0,
                        factory_active: 1'b1};
      capable_reg  <= 1'b0;
      init_cnt_reg <= 8'h00;
    end else begin
      state_reg    <= state_next;
      page_reg     <= page_next;
      ctrl_reg     <= ctrl_next;
      status_reg   <= status_next;
      capable_reg  <= capable_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign load_page  = page_reg;
  assign load_start = (state_reg == RUCL_ST_LOAD);
  assign status     = status_reg;
  assign user_mode  = (state_reg == RUCL_ST_USER);
  // Pins tri-stated and pulled up until user mode
  assign io_oe_n    = !user_mode;
  assign io_pullup  = !user_mode;
  // User registers held in reset until initialization ends
  assign user_reset_n = (state_reg == RUCL_ST_USER);
  assign chain_cfg_enable_out = !user_mode;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_powerup_factory;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == RUCL_ST_RESET) |=> (page_reg == `RUCL_FACTORY_PAGE);
  endproperty
  a_powerup_factory: assert property (p_powerup_factory)
    else $error("start page not factory");

  property p_err_fallback;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == RUCL_ST_LOAD && load_error && !pin_fall) |=>
        (page_reg == `RUCL_FACTORY_PAGE &&
         status_reg.cause == `RUCL_CAUSE_LOAD_ERR);
  endproperty
  a_err_fallback: assert property (p_err_fallback)
    else $error("load error did not fall back");

  property p_wd_fallback;
    @(posedge clock) disable iff (!rst_n)
      (wd_expired && !pin_fall) |=>
        (state_reg == RUCL_ST_LOAD && is_factory &&
         status_reg.cause == `RUCL_CAUSE_WATCHDOG);
  endproperty
  a_wd_fallback: assert property (p_wd_fallback)
    else $error("watchdog expiry did not reload factory");

  property p_wd_off_factory;
    @(posedge clock) disable iff (!rst_n)
      is_factory |-> !wd_run;
  endproperty
  a_wd_off_factory: assert property (p_wd_off_factory)
    else $error("watchdog running in factory image");

  property p_restart_valid;
    @(posedge clock) disable iff (!rst_n)
      (wd_restart && !capable_reg) |-> !wd_ok_restart;
  endproperty
  a_restart_valid: assert property (p_restart_valid)
    else $error("restart from invalid image accepted");

  property p_init_len;
    @(posedge clock) disable iff (!rst_n)
      ($rose(state_reg == RUCL_ST_INIT) && !pin_fall) |->
        (state_reg == RUCL_ST_INIT)[*8] ##1 user_mode;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init length wrong");

  property p_io_tristate;
    @(posedge clock) disable iff (!rst_n)
      !user_mode |-> (io_oe_n && io_pullup && !user_reset_n);
  endproperty
  a_io_tristate: assert property (p_io_tristate)
    else $error("pins driven outside user mode");

  property p_pin_reload;
    @(posedge clock) disable iff (!rst_n)
      (pin_fall && state_reg != RUCL_ST_RESET) |=>
        (state_reg == RUCL_ST_LOAD && status_reg.cause == `RUCL_CAUSE_PIN);
  endproperty
  a_pin_reload: assert property (p_pin_reload)
    else $error("reconfig pin ignored");

  property p_page_range;
    @(posedge clock) disable iff (!rst_n)
      ctrl_reg.wd_enable |-> page_is_app(ctrl_reg.next_page);
  endproperty
  a_page_range: assert property (p_page_range)
    else $error("control page is factory");

  c_user:     cover property (@(posedge clock) disable iff (!rst_n)
                $rose(user_mode));
  c_wd:       cover property (@(posedge clock) disable iff (!rst_n)
                wd_expired);
  c_err:      cover property (@(posedge clock) disable iff (!rst_n)
                load_error && load_start);

endmodule : rucl_loader

// File: verification/rucl_mem_model.sv
// Paged configuration memory model facing the loader's load interface.
// Assumes the loader holds load_start and load_page for a whole load.
`timescale 1ns/1ps

module rucl_mem_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       load_start,
  input  wire logic [2:0] load_page,
  input  wire logic [7:0] bad_mask,
  input  wire logic [7:0] nocap_mask,
  output logic            load_done,
  output logic            load_error,
  output logic            image_remote_capable
);
  logic [1:0] wait_reg;
  logic       answered_reg;
  logic [2:0] page_reg;
  logic       bad;

  // ----------------------------------------------------------------------
  // Image table
  // ----------------------------------------------------------------------
  // The factory page is written once and never corrupted
  assign bad = (load_page != 3'h0) && bad_mask[load_page];
  // Only application pages are built for remote update
  assign image_remote_capable = (load_page != 3'h0) && !nocap_mask[load_page];

  // Answer each load once, three cycles after it starts; re-arm on a new page
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg     <= 2'h0;
      answered_reg <= 1'b0;
      page_reg     <= 3'h0;
      load_done    <= 1'b0;
      load_error   <= 1'b0;
    end else begin
      load_done  <= 1'b0;
      load_error <= 1'b0;
      page_reg   <= load_page;
      if (!load_start || load_page != page_reg) begin
        wait_reg     <= 2'h0;
        answered_reg <= 1'b0;
      end else if (!answered_reg) begin
        if (wait_reg == 2'h2) begin
          answered_reg <= 1'b1;
          load_error   <= bad;
          load_done    <= !bad;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule : rucl_mem_model

// File: verification/remote_update_config_loader_bench.sv
// Self-checking bench for the configuration loader and a memory model.
// Assumes inputs change at the falling clock edge.
`timescale 1ns/1ps
`include "rucl_defines.svh"

module remote_update_config_loader_bench;
  import rucl_pkg::*;

  logic         clock, arst_n, reconfig_pin_n, ctrl_write;
  logic         wd_restart, reconfig_req, chain_out, chain_in;
  logic         load_start, load_done, load_error, capable;
  logic         user_mode, io_oe_n, io_pullup, user_reset_n;
  logic [2:0]   load_page;
  logic [7:0]   bad_mask, nocap_mask;
  rucl_ctrl_t   ctrl;
  rucl_status_t status;
  int           n_errors, n_checks, p, n;

  rucl_loader dut (
    .clock(clock), .arst_n(arst_n), .reconfig_pin_n(reconfig_pin_n),
    .chain_cfg_enable_in(chain_in), .chain_cfg_enable_out(chain_out),
    .load_page(load_page), .load_start(load_start), .load_done(load_done),
    .load_error(load_error), .image_remote_capable(capable),
    .ctrl_write(ctrl_write), .ctrl_in(ctrl), .wd_restart(wd_restart),
    .reconfig_req(reconfig_req), .status(status), .user_mode(user_mode),
    .io_oe_n(io_oe_n), .io_pullup(io_pullup), .user_reset_n(user_reset_n));

  rucl_mem_model mem (
    .clock(clock), .arst_n(arst_n), .load_start(load_start),
    .load_page(load_page), .bad_mask(bad_mask), .nocap_mask(nocap_mask),
    .load_done(load_done), .load_error(load_error),
    .image_remote_capable(capable));

  // ----------------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask : chk_bit

  task automatic chk_page(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) fail("page mismatch");
  endtask : chk_page

  task automatic chk_cause(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) fail("cause mismatch");
  endtask : chk_cause

  // Bounded wait for user_mode to reach a level
  task automatic wait_mode(input logic lvl, input int bound);
    for (int i = 0; i < bound && user_mode !== lvl; i++) cyc(1);
    if (user_mode !== lvl) begin
      fail("wait timed out");
      stop_test();
    end
  endtask : wait_mode

  // Bounded wait for load_start to reach a level
  task automatic wait_load(input logic lvl, input int bound);
    for (int i = 0; i < bound && load_start !== lvl; i++) cyc(1);
    if (load_start !== lvl) begin
      fail("load wait timed out");
      stop_test();
    end
  endtask : wait_load

  // Factory writes the control word with a one-cycle ctrl_write pulse
  task automatic write_ctrl(input logic [2:0] pg, input logic en,
                            input logic [11:0] to);
    ctrl = '{next_page: pg, wd_enable: en, wd_timeout: to};
    ctrl_write = 1'b1;
    cyc(1);
    ctrl_write = 1'b0;
  endtask : write_ctrl

  // One-cycle reload request, then a bounded wait for user mode
  task automatic reload();
    reconfig_req = 1'b1;
    cyc(1);
    reconfig_req = 1'b0;
    wait_mode(1'b1, 200);
  endtask : reload

  // Control write, one idle cycle, then the reload request
  task automatic factory_load(input logic [2:0] pg, input logic en,
                              input logic [11:0] to);
    write_ctrl(pg, en, to);
    cyc(1);
    reload();
  endtask : factory_load

  // Restart pulses every 19 cycles, well inside four ticks of 16
  task automatic restarts(input int k);
    repeat (k) begin
      cyc(18);
      wd_restart = 1'b1;
      cyc(1);
      wd_restart = 1'b0;
    end
  endtask : restarts

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    reconfig_pin_n = 1'b1;
    chain_in = 1'b1;
    ctrl_write = 1'b0;
    wd_restart = 1'b0;
    reconfig_req = 1'b0;
    bad_mask = 8'h20;
    nocap_mask = 8'h10;
    ctrl = '0;
    cyc(4);
    arst_n = 1'b1;

    // Loading waits for the chain enable, then starts at the factory page
    cyc(10);
    chk_bit(load_start, 1'b0, "load without chain enable");
    chain_in = 1'b0;
    wait_load(1'b1, 50);
    chk_page(load_page, `RUCL_FACTORY_PAGE);
    chk_bit(io_oe_n, 1'b1, "pins driven in load");
    chk_bit(io_pullup, 1'b1, "no pull-up in load");
    chk_bit(chain_out, 1'b1, "chain enabled early");
    wait_load(1'b0, 50);
    for (n = 0; n < 50 && user_mode !== 1'b1; n++) cyc(1);
    chk_bit(n == `RUCL_INIT_CYC, 1'b1, "init length");
    wait_mode(1'b1, 1);
    chk_bit(io_oe_n, 1'b0, "pins not enabled");
    chk_bit(io_pullup, 1'b0, "pull-up left on");
    chk_bit(user_reset_n, 1'b1, "user reset held");
    chk_bit(chain_out, 1'b0, "chain not passed");
    chk_cause(status.cause, `RUCL_CAUSE_POWERUP);
    $display("test powerup done");

    // Every application page except the corrupt page 5, then back to the factory image
    for (p = 1; p <= `RUCL_MAX_APP_PAGES; p++) begin
      if (p == 5) continue;
      factory_load(p[2:0], 1'b0, 12'h000);
      chk_page(load_page, p[2:0]);
      chk_bit(status.factory_active, 1'b0, "not app");
      cyc(2);
      reload();
      chk_page(load_page, `RUCL_FACTORY_PAGE);
      chk_bit(status.factory_active, 1'b1, "not fact");
    end
    $display("test pages done");

    // Corrupt page falls back to the factory image
    factory_load(3'h5, 1'b0, 12'h000);
    chk_page(load_page, `RUCL_FACTORY_PAGE);
    chk_cause(status.cause, `RUCL_CAUSE_LOAD_ERR);
    chk_page(status.failed_page, 3'h5);
    $display("test load error done");

    // Kept alive by restarts, then left to expire
    factory_load(3'h2, 1'b1, 12'h004);
    restarts(10);
    chk_bit(user_mode, 1'b1, "restart ignored");
    chk_page(load_page, 3'h2);
    wait_mode(1'b0, 300);
    wait_mode(1'b1, 200);
    chk_page(load_page, `RUCL_FACTORY_PAGE);
    chk_cause(status.cause, `RUCL_CAUSE_WATCHDOG);
    chk_page(status.failed_page, 3'h2);
    $display("test watchdog done");

    // An image not built for remote update cannot restart the counter
    factory_load(3'h4, 1'b1, 12'h004);
    restarts(8);
    chk_page(load_page, `RUCL_FACTORY_PAGE);
    chk_cause(status.cause, `RUCL_CAUSE_WATCHDOG);
    chk_page(status.failed_page, 3'h4);
    cyc(200);
    chk_bit(user_mode, 1'b1, "factory timed out");
    chk_page(load_page, `RUCL_FACTORY_PAGE);
    $display("test restart refused done");

    // The reconfiguration pin forces a reload from an application
    factory_load(3'h1, 1'b0, 12'h000);
    write_ctrl(3'h3, 1'b0, 12'h000);
    reconfig_pin_n = 1'b0;
    wait_mode(1'b0, 20);
    chk_bit(io_oe_n, 1'b1, "pins driven on reload");
    reconfig_pin_n = 1'b1;
    wait_mode(1'b1, 200);
    chk_page(load_page, `RUCL_FACTORY_PAGE);
    chk_cause(status.cause, `RUCL_CAUSE_PIN);
    $display("test pin done");

    // Writes from an application or naming page zero leave the control word
    write_ctrl(`RUCL_FACTORY_PAGE, 1'b0, 12'h000);
    cyc(1);
    reload();
    chk_page(load_page, 3'h1);
    $display("test refused writes done");
    stop_test();
  end
endmodule : remote_update_config_loader_bench
